// ### core/mfo_pkg.sv
// mfo_pkg: constants for the multi-function status output selector.
// assumes one 50 MHz control clock and a plain byte-addressed register port.
package mfo_pkg;
  // register byte addresses
  localparam logic [7:0] ADR_FSEL0   = 8'h00;
  localparam logic [7:0] ADR_FSEL1   = 8'h04;
  localparam logic [7:0] ADR_FSEL2   = 8'h08;
  localparam logic [7:0] ADR_FSEL3   = 8'h0c;
  localparam logic [7:0] ADR_FLVL    = 8'h10;
  localparam logic [7:0] ADR_FWID    = 8'h14;
  localparam logic [7:0] ADR_MINF    = 8'h18;
  localparam logic [7:0] ADR_ZHOLD   = 8'h1c;
  localparam logic [7:0] ADR_UVL     = 8'h20;
  localparam logic [7:0] ADR_TQL1    = 8'h24;
  localparam logic [7:0] ADR_TQT1    = 8'h28;
  localparam logic [7:0] ADR_TQL2    = 8'h2c;
  localparam logic [7:0] ADR_TQT2    = 8'h30;
  localparam logic [7:0] ADR_COMM    = 8'h34;
  localparam logic [7:0] ADR_STATUS  = 8'h38;
  // reset values of the function selections
  localparam logic [7:0] RST_FSEL0   = 8'h00;
  localparam logic [7:0] RST_FSEL1   = 8'h0b;
  localparam logic [7:0] RST_FSEL2   = 8'h01;
  localparam logic [7:0] RST_FSEL3   = 8'h02;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  // function codes
  localparam logic [7:0] FN_UV       = 8'h05;
  localparam logic [7:0] FN_FAULT    = 8'h0b;
  localparam logic [7:0] FN_COMM     = 8'h0c;
  localparam logic [7:0] FN_DET1     = 8'h10;
  localparam logic [7:0] FN_DET2     = 8'h11;
  localparam logic [7:0] FN_LAST     = 8'h17;
  localparam logic [7:0] FN_INV      = 8'h64;
  localparam logic [7:0] FN_INV_LAST = 8'h95;
  // status register field positions
  localparam int STS_TERM  = 0;
  localparam int STS_DET1  = 4;
  localparam int STS_DET2  = 5;
  localparam int STS_TQ1   = 6;
  localparam int STS_TQ2   = 7;
  // torque time unit is one millisecond
  localparam int TQ_UNIT_NS = 1000000;
  localparam int CLK_NS     = 20;
  localparam int TQ_UNIT_CYC = TQ_UNIT_NS / CLK_NS;
endpackage

// ### core/mfo_core.sv
// mfo_core: four output terminals, each picking one drive condition by code.
// assumes all status inputs come from logic on clk_sys; register port is
// a plain strobe port with read data one cycle after the read strobe.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// [R1] code 1: below zero-hold or minimum frequency
// [R2] code 2: output within width of command
// [R3] code 3: both inside level plus/minus width
// [R4] code 4: ready unless any blocking condition
// [R5] code 5: bus voltage below undervoltage level
// [R6] code 6: closed during baseblock
// [R7] code 8: closed when frequency command from keypad
// [R8] code 9: closed on frequency command loss
// [R9] code 10: closed when run command from keypad
// [R10] code 11: closed while fault active
// [R11] code 12: host sets bit, default open
// [R12] code 13: closed while any alarm active
// [R13] code 14: closed during fault reset attempt
// [R14] code 15: follows timer function output
// [R15] code 16: open above level+width until level
// [R16] code 17: closed above level until level-width
// [R17] code 18: torque over level one for time
// [R18] code 20: torque over level two for time
// [R19] code 22: closed while running reverse
// [R20] code 23: closed when motor two selected
// [R21] four terminals, each with own selection
// [R22] codes 100-149 invert code minus 100
// [R23] outputs registered on control clock
module mfo_core
  import mfo_pkg::*;
#(
  parameter int TICK_CYC = TQ_UNIT_CYC // cycles per torque time unit
) (
  input  wire logic              clk_sys,         // control clock
  input  wire logic              rst_n,           // sync reset
  input  wire logic [7:0]        reg_addr,        // byte address
  input  wire logic [31:0]       reg_wdata,       // write data
  input  wire logic              reg_wr,          // write strobe
  input  wire logic              reg_rd,          // read strobe
  output logic [31:0]            reg_rdata,       // read data
  input  wire logic signed [15:0] output_frequency, // signed output freq
  input  wire logic signed [15:0] freq_cmd,       // signed freq command
  input  wire logic signed [15:0] motor_speed,    // signed encoder speed
  input  wire logic              closed_loop,     // closed-loop vector
  input  wire logic [15:0]       dc_bus,          // bus voltage
  input  wire logic [15:0]       torque_value,    // current or torque
  input  wire logic              running,         // drive outputting
  input  wire logic              ready_to_run,    // able to run
  input  wire logic              power_loss,      // supply lost
  input  wire logic              fault_active,    // fault present
  input  wire logic              int_supply_fail, // internal supply bad
  input  wire logic              param_invalid,   // setting blocks run
  input  wire logic              ov_uv_fault,     // bus fault
  input  wire logic              prog_mode,       // programming mode
  input  wire logic              baseblock,       // switching inhibited
  input  wire logic              freq_src_keypad, // freq cmd from keypad
  input  wire logic              freq_cmd_loss,   // freq cmd lost
  input  wire logic              run_src_keypad,  // run cmd from keypad
  input  wire logic              pid_feedback_high_alarm, // alarm
  input  wire logic              pid_feedback_low_alarm,  // alarm
  input  wire logic              overcurrent_alarm,       // alarm
  input  wire logic              other_alarm,     // any other alarm
  input  wire logic              fault_reset_try, // reset being tried
  input  wire logic              timer_out,       // timer function
  input  wire logic              reverse_run,     // running reverse
  input  wire logic              motor_two_sel,   // motor two chosen
  output logic [3:0]             term_out         // 1 = terminal closed
);

  typedef struct packed {
    logic [3:0][7:0] fsel;
    logic [15:0]     flvl;
    logic [15:0]     fwid;
    logic [15:0]     minf;
    logic [15:0]     zhold;
    logic [15:0]     uvl;
    logic [15:0]     tql1;
    logic [15:0]     tqt1;
    logic [15:0]     tql2;
    logic [15:0]     tqt2;
    logic [3:0]      comm;
    logic            det1;
    logic            det2;
    logic [31:0]     pre1;
    logic [31:0]     pre2;
    logic [15:0]     tc1;
    logic [15:0]     tc2;
    logic [3:0]      term;
    logic [31:0]     rdata;
  } mfo_st_type;

  mfo_st_type st_r;
  mfo_st_type st_nxt;

  // magnitude with saturation so the most negative value stays positive
  function automatic logic [15:0] mag16(input logic signed [15:0] v);
    logic [15:0] m;
    m = v[15] ? 16'(-v) : 16'(v);
    if (v == 16'sh8000) begin
      m = 16'h7fff;
    end
    return m;
  endfunction

  // true when a lies within centre plus or minus width
  function automatic logic in_band(input logic [15:0] a, input logic [15:0] c,
                                   input logic [15:0] w);
    return ({1'b0, a} + {1'b0, w} >= {1'b0, c}) && ({1'b0, a} <= {1'b0, c} + {1'b0, w});
  endfunction

  // maps a function code onto the condition vector, with inversion
  function automatic logic pick(input logic [7:0] code, input logic [23:0] cv);
    logic [7:0] b;
    b = code - FN_INV;
    if (code <= FN_LAST) begin
      return cv[code[4:0]];
    end else if (code >= FN_INV && code <= FN_INV_LAST) begin
      return (b <= FN_LAST) ? !cv[b[4:0]] : 1'b1;
    end
    return 1'b0;
  endfunction

  logic [15:0] mag_f;
  logic [15:0] mag_c;
  logic [15:0] mag_s;
  logic [15:0] mag_d;
  logic [16:0] diff;
  logic        tq_over1;
  logic        tq_over2;
  logic        tq_det1;
  logic        tq_det2;
  logic        tick1;
  logic        tick2;
  logic        ready;
  logic [23:0] cond;
  logic        hit;
  logic [31:0] rsel;

  // frequency magnitudes; closed loop compares measured speed in mag_f and diff, mag_s stays output frequency
  always_comb begin
    mag_f = closed_loop ? mag16(motor_speed) : mag16(output_frequency); // [R15] [R16]
    mag_c = mag16(freq_cmd);
    mag_s = mag16(output_frequency);
    diff  = closed_loop ? 17'({motor_speed[15], motor_speed} - {freq_cmd[15], freq_cmd})
                        : 17'({output_frequency[15], output_frequency}
                              - {freq_cmd[15], freq_cmd}); // [R2]
    mag_d = diff[16] ? 16'(-diff) : diff[15:0];
    if (diff[16] && diff[15:0] == 16'h0000) begin
      mag_d = 16'hffff;
    end
  end

  // torque detectors need the level exceeded without a break
  assign tq_over1 = torque_value > st_r.tql1;
  assign tq_over2 = torque_value > st_r.tql2;
  assign tq_det1  = tq_over1 && (st_r.tc1 >= st_r.tqt1); // [R17]
  assign tq_det2  = tq_over2 && (st_r.tc2 >= st_r.tqt2); // [R18]
  // a tick ends each full unit of continuous excess on that detector
  // time 0 detects at once, since a zero count already meets it
  assign tick1    = st_r.pre1 == 32'(TICK_CYC - 1);
  assign tick2    = st_r.pre2 == 32'(TICK_CYC - 1);

  // a bus fault only blocks readiness while stopped
  assign ready = (ready_to_run || running) && !power_loss && !fault_active
                 && !int_supply_fail && !param_invalid
                 && !(ov_uv_fault && !running) && !prog_mode; // [R4]

  // condition vector indexed by function code; retained codes stay open
  always_comb begin
    cond     = 24'h000000;
    cond[0]  = running;
    cond[1]  = closed_loop ? (mag_s < st_r.zhold) : (mag_s < st_r.minf); // [R1]
    cond[2]  = mag_d <= st_r.fwid; // [R2]
    cond[3]  = in_band(mag_s, st_r.flvl, st_r.fwid)
               && in_band(mag_c, st_r.flvl, st_r.fwid); // [R3]
    cond[4]  = ready; // [R4]
    cond[5]  = dc_bus < st_r.uvl; // [R5]
    cond[6]  = baseblock; // [R6]
    cond[8]  = freq_src_keypad; // [R7]
    cond[9]  = freq_cmd_loss; // [R8]
    cond[10] = run_src_keypad; // [R9]
    cond[11] = fault_active; // [R10]
    cond[13] = pid_feedback_high_alarm || pid_feedback_low_alarm
               || overcurrent_alarm || other_alarm; // [R12]
    cond[14] = fault_reset_try; // [R13]
    cond[15] = timer_out; // [R14]
    cond[16] = !st_r.det1; // [R15]
    cond[17] = st_r.det2; // [R16]
    cond[18] = tq_det1; // [R17]
    cond[20] = tq_det2; // [R18]
    cond[22] = reverse_run; // [R19]
    cond[23] = motor_two_sel; // [R20]
  end

  // read decode; unmapped addresses read as zero
  always_comb begin
    hit  = 1'b1;
    rsel = 32'h00000000;
    unique case (reg_addr)
      ADR_FSEL0:  rsel = {24'h000000, st_r.fsel[0]};
      ADR_FSEL1:  rsel = {24'h000000, st_r.fsel[1]};
      ADR_FSEL2:  rsel = {24'h000000, st_r.fsel[2]};
      ADR_FSEL3:  rsel = {24'h000000, st_r.fsel[3]};
      ADR_FLVL:   rsel = {16'h0000, st_r.flvl};
      ADR_FWID:   rsel = {16'h0000, st_r.fwid};
      ADR_MINF:   rsel = {16'h0000, st_r.minf};
      ADR_ZHOLD:  rsel = {16'h0000, st_r.zhold};
      ADR_UVL:    rsel = {16'h0000, st_r.uvl};
      ADR_TQL1:   rsel = {16'h0000, st_r.tql1};
      ADR_TQT1:   rsel = {16'h0000, st_r.tqt1};
      ADR_TQL2:   rsel = {16'h0000, st_r.tql2};
      ADR_TQT2:   rsel = {16'h0000, st_r.tqt2};
      ADR_COMM:   rsel = {28'h0000000, st_r.comm};
      ADR_STATUS: rsel = {24'h000000, tq_det2, tq_det1, st_r.det2, st_r.det1, st_r.term};
      default:    hit = 1'b0;
    endcase
  end

  // next state: registers, hysteresis, torque timers, terminals
  always_comb begin
    st_nxt = st_r;
    // register writes; status is read-only and unmapped writes are dropped
    if (reg_wr) begin
      unique case (reg_addr)
        ADR_FSEL0: st_nxt.fsel[0] = reg_wdata[7:0]; // [R21]
        ADR_FSEL1: st_nxt.fsel[1] = reg_wdata[7:0];
        ADR_FSEL2: st_nxt.fsel[2] = reg_wdata[7:0];
        ADR_FSEL3: st_nxt.fsel[3] = reg_wdata[7:0];
        ADR_FLVL:  st_nxt.flvl    = reg_wdata[15:0];
        ADR_FWID:  st_nxt.fwid    = reg_wdata[15:0];
        ADR_MINF:  st_nxt.minf    = reg_wdata[15:0];
        ADR_ZHOLD: st_nxt.zhold   = reg_wdata[15:0];
        ADR_UVL:   st_nxt.uvl     = reg_wdata[15:0];
        ADR_TQL1:  st_nxt.tql1    = reg_wdata[15:0];
        ADR_TQT1:  st_nxt.tqt1    = reg_wdata[15:0];
        ADR_TQL2:  st_nxt.tql2    = reg_wdata[15:0];
        ADR_TQT2:  st_nxt.tqt2    = reg_wdata[15:0];
        ADR_COMM:  st_nxt.comm    = reg_wdata[3:0]; // [R11]
        default:   st_nxt.comm    = st_r.comm;
      endcase
    end
    // read data stands only in the cycle after the strobe
    st_nxt.rdata = (reg_rd && hit) ? rsel : 32'h00000000;
    // detection one: trips above level+width, releases at level
    if ({1'b0, mag_f} > {1'b0, st_r.flvl} + {1'b0, st_r.fwid}) begin
      st_nxt.det1 = 1'b1; // [R15]
    end else if (mag_f <= st_r.flvl) begin
      st_nxt.det1 = 1'b0;
    end
    // detection two: trips above level, releases at level-width
    if (mag_f > st_r.flvl) begin
      st_nxt.det2 = 1'b1; // [R16]
    end else if ({1'b0, mag_f} + {1'b0, st_r.fwid} <= {1'b0, st_r.flvl}) begin
      st_nxt.det2 = 1'b0;
    end
    // each torque timer owns its prescaler, restarted with its excess, so a
    // time of n units needs n full units over the level; a shared free-running
    // prescaler would let detection come up to one unit early
    if (!tq_over1) begin
      st_nxt.pre1 = 32'h00000000; // [R17]
      st_nxt.tc1  = 16'h0000;
    end else if (tick1) begin
      st_nxt.pre1 = 32'h00000000;
      if (st_r.tc1 != 16'hffff) begin
        st_nxt.tc1 = st_r.tc1 + 16'h0001; // saturates
      end
    end else begin
      st_nxt.pre1 = st_r.pre1 + 32'h00000001;
    end
    if (!tq_over2) begin
      st_nxt.pre2 = 32'h00000000; // [R18]
      st_nxt.tc2  = 16'h0000;
    end else if (tick2) begin
      st_nxt.pre2 = 32'h00000000;
      if (st_r.tc2 != 16'hffff) begin
        st_nxt.tc2 = st_r.tc2 + 16'h0001; // saturates
      end
    end else begin
      st_nxt.pre2 = st_r.pre2 + 32'h00000001;
    end
    // each terminal picks its own condition, then the host bit for code 12
    for (int i = 0; i < 4; i++) begin
      st_nxt.term[i] = pick(st_r.fsel[i], cond); // [R22] [R23]
      if (st_r.fsel[i] == FN_COMM) begin
        st_nxt.term[i] = st_r.comm[i]; // [R11]
      end else if (st_r.fsel[i] == FN_INV + FN_COMM) begin
        st_nxt.term[i] = !st_r.comm[i]; // [R22]
      end
    end
  end

  // single state register, synchronous reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r         <= '0;
      st_r.fsel[0] <= RST_FSEL0;
      st_r.fsel[1] <= RST_FSEL1;
      st_r.fsel[2] <= RST_FSEL2;
      st_r.fsel[3] <= RST_FSEL3;
      st_r.flvl    <= RST_WORD;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign term_out  = st_r.term;
  assign reg_rdata = st_r.rdata;

  // checks on terminal selection, hysteresis, timers and the read port
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_fault_select: assert property ( // [R10]
    (st_r.fsel[0] == FN_FAULT && fault_active) |=> term_out[0])
    else $error("fault code did not close terminal");
  a_inverse_fault: assert property ( // [R22]
    (st_r.fsel[1] == FN_INV + FN_FAULT && fault_active) |=> !term_out[1])
    else $error("inverted fault code did not open terminal");
  a_uv_select: assert property ( // [R5]
    (st_r.fsel[0] == FN_UV && dc_bus < st_r.uvl) |=> term_out[0])
    else $error("undervoltage did not close terminal");
  a_comm_bit: assert property ( // [R11]
    (st_r.fsel[2] == FN_COMM) |=> term_out[2] == $past(st_r.comm[2]))
    else $error("host bit not shown on terminal");
  a_det1_hold: assert property ( // [R15]
    (st_r.det1 && mag_f > st_r.flvl) |=> st_r.det1)
    else $error("detection one released above level");
  a_det2_trip: assert property ( // [R16]
    (mag_f > st_r.flvl) |=> st_r.det2)
    else $error("detection two did not trip above level");
  a_det1_term: assert property ( // [R15]
    (st_r.fsel[0] == FN_DET1 && st_r.det1) |=> !term_out[0])
    else $error("detection one terminal not open above threshold");
  a_torque_restart: assert property ( // [R17]
    !tq_over1 |=> st_r.tc1 == 16'h0000)
    else $error("torque timer one not restarted");
  a_read_status: assert property ( // [R23]
    (reg_rd && reg_addr == ADR_STATUS) |=> reg_rdata[3:0] == $past(term_out))
    else $error("status read returned wrong terminals");
  a_read_once: assert property (
    !reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data stood without a read");

  // release points of both bands, the inverted host bit and the status fields
  a_det1_release: assert property ( // [R15]
    (mag_f <= st_r.flvl) |=> !st_r.det1)
    else $error("detection one held at or below level");
  a_det2_release: assert property ( // [R16]
    ({1'b0, mag_f} + {1'b0, st_r.fwid} <= {1'b0, st_r.flvl}) |=> !st_r.det2)
    else $error("detection two held below level minus width");
  a_det2_term: assert property ( // [R16]
    (st_r.fsel[1] == FN_DET2 && st_r.det2) |=> term_out[1])
    else $error("detection two terminal not closed");
  a_comm_inverse: assert property ( // [R22]
    (st_r.fsel[3] == FN_INV + FN_COMM) |=> term_out[3] == !$past(st_r.comm[3]))
    else $error("inverted host bit not shown on terminal");
  a_torque_restart2: assert property ( // [R18]
    !tq_over2 |=> st_r.tc2 == 16'h0000)
    else $error("torque timer two not restarted");
  a_status_dets: assert property ( // [R23]
    (reg_rd && reg_addr == ADR_STATUS) |=> reg_rdata[5:4] == $past({st_r.det2, st_r.det1}))
    else $error("status read returned wrong detection bits");

  c_fault_close: cover property (st_r.fsel[1] == FN_FAULT ##1 term_out[1]);
  c_det1_cycle: cover property (st_r.det1 ##[1:100] !st_r.det1);
  c_torque_hit: cover property (tq_over1 && !tq_det1 ##1 tq_det1);
  c_comm_write: cover property (reg_wr && reg_addr == ADR_COMM);
  c_inverse_open: cover property (st_r.fsel[1] == FN_INV + FN_FAULT ##1 !term_out[1]);

endmodule

`default_nettype wire

// ### test/mfo_plc_model.sv
// mfo_plc_model: external controller that reads the four output terminals.
// assumes terminals are sampled on the drive's control clock, no filtering.
`timescale 1ns/10ps
`default_nettype none

module mfo_plc_model (
  input  wire logic       clk_sys, // control clock
  input  wire logic [3:0] term_in, // terminal levels, 1 = closed
  output logic      [3:0] seen     // last sampled terminal image
);
  // input register of the controller; adds one cycle of view latency
  always_ff @(posedge clk_sys) begin
    seen <= term_in;
  end
endmodule

`default_nettype wire

// ### test/multi_function_status_output_tb.sv
// multi_function_status_output_tb: register-port tests of the terminal selector.
// assumes mfo_core with a short torque tick and the controller model reading terminals.
`timescale 1ns/10ps
`default_nettype none

module multi_function_status_output_tb;
  import mfo_pkg::*;
  logic              clk_sys, rst_n, reg_wr, reg_rd, cl;
  logic        [7:0]  reg_addr;
  logic        [31:0] reg_wdata, reg_rdata;
  logic signed [15:0] fq, fc, ms;
  logic        [15:0] dcb, tq;
  logic        [19:0] fl;
  logic        [3:0]  term_out, seen;
  int                 bad_count, n_checks, k;
  // single-flag codes and the flag bit that each one follows
  logic        [7:0]  cd [14] = '{8'h00, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0d,
                                 8'h0d, 8'h0d, 8'h0d, 8'h0e, 8'h0f, 8'h16, 8'h17};
  int                 bt [14] = '{0, 8, 9, 10, 11, 3, 12, 13, 14, 15, 16, 17, 18, 19};

  mfo_core #(.TICK_CYC(4)) i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .output_frequency(fq),
    .freq_cmd(fc), .motor_speed(ms), .closed_loop(cl), .dc_bus(dcb), .torque_value(tq),
    .running(fl[0]), .ready_to_run(fl[1]), .power_loss(fl[2]), .fault_active(fl[3]),
    .int_supply_fail(fl[4]), .param_invalid(fl[5]), .ov_uv_fault(fl[6]),
    .prog_mode(fl[7]), .baseblock(fl[8]), .freq_src_keypad(fl[9]),
    .freq_cmd_loss(fl[10]), .run_src_keypad(fl[11]), .pid_feedback_high_alarm(fl[12]),
    .pid_feedback_low_alarm(fl[13]), .overcurrent_alarm(fl[14]), .other_alarm(fl[15]),
    .fault_reset_try(fl[16]), .timer_out(fl[17]), .reverse_run(fl[18]),
    .motor_two_sel(fl[19]), .term_out(term_out));

  mfo_plc_model i_plc (.clk_sys(clk_sys), .term_in(term_out), .seen(seen));

  // free-running 50 MHz control clock
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    n_checks++;
    if (reg_rdata !== e) begin
      bad_count++;
      $display("unexpected at %0t: read %h got %h exp %h", $time, a, reg_rdata, e);
    end
  endtask

  // three edges cover the 2-cycle hysteresis path plus the controller's sample
  task automatic ck(input logic [3:0] m, input logic [3:0] e);
    repeat (3) @(posedge clk_sys);
    #1;
    n_checks++;
    if ((seen & m) !== e) begin
      bad_count++;
      $display("unexpected at %0t: terminals %b exp %b", $time, seen & m, e);
    end
  endtask

  task automatic setf(input logic signed [15:0] f, input logic signed [15:0] c);
    @(posedge clk_sys);
    fq <= f;
    fc <= c;
  endtask

  initial begin
    {reg_wr, reg_rd, cl, reg_addr, reg_wdata, fq, fc, ms, dcb, tq, fl} = '0;
    bad_count = 0;
    n_checks = 0;
    rst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset values and the unmapped hole
    rd(ADR_FSEL0, {24'h0, RST_FSEL0});
    rd(ADR_FSEL1, {24'h0, RST_FSEL1});
    rd(ADR_FSEL2, {24'h0, RST_FSEL2});
    rd(ADR_FSEL3, {24'h0, RST_FSEL3});
    wr(8'h3c, 32'h0000_00ff);
    rd(8'h3c, 32'h0);
    $display("test reset done");
    // every single-flag code, plain and inverted
    for (int i = 0; i < 14; i++) begin
      wr(ADR_FSEL0, {24'h0, cd[i]});
      wr(ADR_FSEL1, {24'h0, cd[i] + 8'h64});
      @(posedge clk_sys);
      fl <= 20'h1 << bt[i];
      ck(4'h3, 4'h1);
      @(posedge clk_sys);
      fl <= '0;
      ck(4'h3, 4'h2);
    end
    $display("test flags done");
    // ready is lost to each blocking condition; bus fault only when stopped
    wr(ADR_FSEL0, 32'h4);
    for (int b = 2; b < 8; b++) begin
      @(posedge clk_sys);
      fl <= 20'h2;
      ck(4'h1, 4'h1);
      @(posedge clk_sys);
      fl <= 20'h2 | (20'h1 << b);
      ck(4'h1, 4'h0);
    end
    @(posedge clk_sys);
    fl <= 20'h41;
    ck(4'h1, 4'h1);
    @(posedge clk_sys);
    fl <= '0;
    // undervoltage around the level
    wr(ADR_UVL, 32'd100);
    wr(ADR_FSEL0, 32'h5);
    @(posedge clk_sys);
    dcb <= 16'd99;
    ck(4'h1, 4'h1);
    @(posedge clk_sys);
    dcb <= 16'd101;
    ck(4'h1, 4'h0);
    $display("test ready and voltage done");
    // zero-speed level switches with the control method
    wr(ADR_MINF, 32'd10);
    wr(ADR_ZHOLD, 32'd30);
    wr(ADR_FSEL0, 32'h1);
    setf(-16'sd9, 16'sd0);
    ck(4'h1, 4'h1);
    setf(16'sd10, 16'sd0);
    ck(4'h1, 4'h0);
    @(posedge clk_sys);
    cl <= 1'b1;
    setf(16'sd20, 16'sd0);
    ck(4'h1, 4'h1);
    setf(-16'sd30, 16'sd0);
    ck(4'h1, 4'h0);
    // speed agree uses motor speed in closed loop
    wr(ADR_FWID, 32'd5);
    wr(ADR_FSEL0, 32'h2);
    @(posedge clk_sys);
    ms <= -16'sd104;
    setf(16'sd0, -16'sd100);
    ck(4'h1, 4'h1);
    @(posedge clk_sys);
    cl <= 1'b0;
    setf(-16'sd100, -16'sd106);
    ck(4'h1, 4'h0);
    setf(-16'sd100, -16'sd104);
    ck(4'h1, 4'h1);
    // user-defined agree in both directions
    wr(ADR_FLVL, 32'd100);
    wr(ADR_FSEL0, 32'h3);
    setf(16'sd103, -16'sd97);
    ck(4'h1, 4'h1);
    setf(16'sd103, 16'sd94);
    ck(4'h1, 4'h0);
    $display("test frequency agree done");
    // both hysteresis bands, level 100 width 20
    wr(ADR_FWID, 32'd20);
    wr(ADR_FSEL0, 32'h10);
    wr(ADR_FSEL1, 32'h11);
    setf(16'sd0, 16'sd0);
    ck(4'h3, 4'h1);
    setf(-16'sd110, 16'sd0);
    ck(4'h3, 4'h3);
    setf(16'sd125, 16'sd0);
    ck(4'h3, 4'h2);
    setf(16'sd105, 16'sd0);
    ck(4'h3, 4'h2);
    setf(-16'sd90, 16'sd0);
    ck(4'h3, 4'h3);
    setf(16'sd80, 16'sd0);
    ck(4'h3, 4'h1);
    $display("test hysteresis done");
    // host-driven bits on the open collectors, one inverted
    wr(ADR_FSEL2, 32'hc);
    wr(ADR_FSEL3, 32'h70);
    ck(4'hc, 4'h8);
    wr(ADR_COMM, 32'h4);
    ck(4'hc, 4'hc);
    wr(ADR_COMM, 32'h8);
    ck(4'hc, 4'h0);
    // torque one needs 2 units of 4-cycle ticks, torque two acts at once
    wr(ADR_TQL1, 32'd50);
    wr(ADR_TQT1, 32'd2);
    wr(ADR_TQL2, 32'd200);
    wr(ADR_FSEL0, 32'h12);
    wr(ADR_FSEL1, 32'h14);
    @(posedge clk_sys);
    tq <= 16'd100;
    ck(4'h3, 4'h0);
    k = 0;
    while (seen[0] !== 1'b1 && k < 40) begin
      @(posedge clk_sys);
      #1;
      k++;
    end
    n_checks++;
    // 2 units of 4 cycles, less the 3 edges of ck, plus terminal and controller stages
    if (k != 7) begin
      bad_count++;
      $display("unexpected at %0t: torque one after %0d cycles", $time, k);
      end_sim();
    end
    @(posedge clk_sys);
    tq <= 16'd250;
    ck(4'h3, 4'h3);
    rd(ADR_STATUS, 32'h0000_00c3);
    @(posedge clk_sys);
    tq <= 16'd0;
    ck(4'h3, 4'h0);
    $display("test terminals and torque done");
    end_sim();
  end
endmodule

`default_nettype wire
